// [design/mac_status_flags.sv]
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
module mac_status_flags
  import status_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  input  wire events_s     ev,
  output actions_s         act,
  output logic [1:0]       tx_state,
  output logic [1:0]       rx_state,
  output logic             remote_start_pin,
  output logic             irq
);
  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        do_wr;
  logic [6:0]  flags_q, flags_d;
  logic [1:0]  om_q, om_d, txs_q, txs_d, rxs_q, rxs_d;
  logic        ie_q, ie_d, dn_q, dn_d, irq_q, irq_d, pin_q, pin_d;
  logic [2:0]  pcnt_q, pcnt_d;
  actions_s    act_q, act_d;
  logic [31:0] status_w;
  logic        summary;
  logic        clr_st;
  logic [6:0]  clr_mask;

  assign do_wr   = aw_q && w_q && !bv_q;
  assign summary = |flags_q[5:0];
  assign status_w = {13'h0000, om_q, dn_q, RSVD_ONES, flags_q, summary};

  always_comb begin
    aw_d  = aw_q;
    w_d   = w_q;
    awa_d = awa_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    bv_d  = bv_q;
    br_d  = br_q;
    rv_d  = rv_q;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (s_awvalid && !aw_q) begin
      aw_d  = 1'b1;
      awa_d = s_awaddr;
    end
    if (s_wvalid && !w_q) begin
      w_d  = 1'b1;
      wd_d = s_wdata;
      ws_d = s_wstrb;
    end
    if (do_wr) begin
      aw_d = 1'b0;
      w_d  = 1'b0;
      bv_d = 1'b1;
      br_d = (awa_q[7:2] == STATUS_OFFS[7:2] || awa_q[7:2] == CONTROL_OFFS[7:2])
             ? RESP_OKAY : RESP_SLVERR;
    end else if (bv_q && s_bready) begin
      bv_d = 1'b0;
    end
    if (s_arvalid && !rv_q) begin
      rv_d = 1'b1;
      if (s_araddr[7:2] == STATUS_OFFS[7:2]) begin
        rd_d = status_w;
        rr_d = RESP_OKAY;
      end else if (s_araddr[7:2] == CONTROL_OFFS[7:2]) begin
        rd_d = {29'h0000_0000, om_q, ie_q};
        rr_d = RESP_OKAY;
      end else begin
        rd_d = 32'h0000_0000;
        rr_d = RESP_SLVERR;
      end
    end else if (rv_q && s_rready) begin
      rv_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status flags and process states
  // ----------------------------------------------------------------
  assign clr_st   = do_wr && awa_q[7:2] == STATUS_OFFS[7:2] && ws_q[0];
  assign clr_mask = clr_st ? wd_q[7:1] : 7'h00;

  always_comb begin
    logic [6:0] set_v;
    set_v    = 7'h00;
    txs_d    = txs_q;
    rxs_d    = rxs_q;
    om_d     = om_q;
    ie_d     = ie_q;
    dn_d     = dn_q;
    pin_d    = pin_q;
    pcnt_d   = pcnt_q;
    act_d    = '0;
    if (do_wr && awa_q[7:2] == CONTROL_OFFS[7:2] && ws_q[0]) begin
      ie_d = wd_q[CTL_IE_BIT];
      om_d = wd_q[CTL_OM_LSB +: 2];
    end
    if (ev.tx_start || ev.tx_poll) txs_d = PS_RUNNING;
    if (ev.rx_start) rxs_d = PS_RUNNING;
    if (ev.rx_poll || (rxs_q == PS_SUSPENDED && ev.rx_recognized)) begin
      rxs_d = PS_RUNNING;
    end
    if (ev.vacc_start) dn_d = 1'b0;
    if (ev.vacc_done) dn_d = 1'b1;
    if (ev.tx_ic_done) set_v[0] = 1'b1;
    if (ev.tx_list_end || ev.tx_local_abort) begin
      set_v[0] = 1'b1;
      txs_d    = PS_SUSPENDED;
    end
    if (ev.rx_frame_done) set_v[1] = 1'b1;
    if (ev.rx_unavail && rxs_q != PS_SUSPENDED) begin
      set_v[2] = 1'b1;
      rxs_d    = PS_SUSPENDED;
    end
    if (ev.rx_wdog) begin
      set_v[4] = 1'b1;
      set_v[1] = 1'b1;
      act_d.rx_abort_mark = 1'b1;
    end
    if (ev.tx_wdog) begin
      set_v[5] = 1'b1;
      txs_d    = PS_STOPPED;
      act_d.tx_wdog_mark = 1'b1;
    end
    if (ev.bus_err || ev.parity_err) begin
      set_v[3] = 1'b1;
      txs_d    = PS_STOPPED;
      rxs_d    = PS_STOPPED;
    end
    if (pcnt_q != 3'h0) pcnt_d = pcnt_q - 3'h1;
    if (ev.boot_msg) begin
      set_v[6] = 1'b1;
      pcnt_d   = 3'(START_PIN_CYC); // pin stands the full count, boot edge included
    end
    pin_d = ev.boot_msg || pcnt_d != 3'h0;
    act_d.medium_off  = (om_d == OM_INT_LOOP);
    act_d.loop_return = (om_d == OM_INT_LOOP) || (om_d == OM_EXT_LOOP);
    flags_d = (flags_q & ~clr_mask) | set_v; // set wins over clear
    irq_d   = ie_d && (|flags_d[5:0]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q    <= 1'b0;
      w_q     <= 1'b0;
      awa_q   <= 8'h00;
      wd_q    <= 32'h0000_0000;
      ws_q    <= 4'h0;
      bv_q    <= 1'b0;
      br_q    <= RESP_OKAY;
      rv_q    <= 1'b0;
      rd_q    <= 32'h0000_0000;
      rr_q    <= RESP_OKAY;
      flags_q <= 7'h00;
      om_q    <= OM_RESET;
      txs_q   <= PS_STOPPED;
      rxs_q   <= PS_STOPPED;
      ie_q    <= 1'b0;
      dn_q    <= 1'b1;
      irq_q   <= 1'b0;
      pin_q   <= 1'b0;
      pcnt_q  <= 3'h0;
      act_q   <= '0;
    end else begin
      aw_q    <= aw_d;
      w_q     <= w_d;
      awa_q   <= awa_d;
      wd_q    <= wd_d;
      ws_q    <= ws_d;
      bv_q    <= bv_d;
      br_q    <= br_d;
      rv_q    <= rv_d;
      rd_q    <= rd_d;
      rr_q    <= rr_d;
      flags_q <= flags_d;
      om_q    <= om_d;
      txs_q   <= txs_d;
      rxs_q   <= rxs_d;
      ie_q    <= ie_d;
      dn_q    <= dn_d;
      irq_q   <= irq_d;
      pin_q   <= pin_d;
      pcnt_q  <= pcnt_d;
      act_q   <= act_d;
    end
  end

  // skid-free: ready low while a channel is held
  assign s_awready        = !aw_q;
  assign s_wready         = !w_q;
  assign s_bvalid         = bv_q;
  assign s_bresp          = br_q;
  assign s_arready        = !rv_q;
  assign s_rvalid         = rv_q;
  assign s_rdata          = rd_q;
  assign s_rresp          = rr_q;
  assign act              = act_q;
  assign tx_state         = txs_q;
  assign rx_state         = rxs_q;
  assign remote_start_pin = pin_q;
  assign irq              = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_summary_or: assert property (rv_q && rr_q == RESP_OKAY && rd_q[15:8] == RSVD_ONES
    |-> rd_q[0] == |rd_q[6:1]) else $error("summary mismatch");
  a_rsvd_ones: assert property ($rose(rv_q) && rr_q == RESP_OKAY && !$past(s_araddr[2])
    |-> rd_q[15:8] == RSVD_ONES) else $error("reserved not ones");
  a_boot_pin: assert property (ev.boot_msg |=> pin_q && flags_q[6] ##1 pin_q [*5])
    else $error("start pin short");
  a_txwd_stop: assert property (ev.tx_wdog |=> flags_q[5] && txs_q == PS_STOPPED
    && act_q.tx_wdog_mark) else $error("tx watchdog");
  a_rxwd_flags: assert property (ev.rx_wdog |=> flags_q[4] && flags_q[1]
    && act_q.rx_abort_mark) else $error("rx watchdog");
  a_fault_stop: assert property (ev.bus_err |=> flags_q[3] && txs_q == PS_STOPPED
    && rxs_q == PS_STOPPED) else $error("fault stop");
  a_ru_suspend: assert property (ev.rx_unavail && rxs_q == PS_RUNNING && !ev.bus_err
    |=> flags_q[2] && rxs_q == PS_SUSPENDED) else $error("rx unavailable");
  a_clear_w1c: assert property (clr_st && wd_q[2] && !ev.rx_frame_done && !ev.rx_wdog
    |=> !flags_q[1]) else $error("w1c clear");
  a_irq_level: assert property (irq_q == (ie_q && summary)) else $error("irq level");
  a_done_reset: assert property ($rose(aresetn) |-> dn_q) else $error("done reset");

  c_irq: cover property ($rose(irq_q));
  c_write: cover property (do_wr ##[1:5] s_bvalid && s_bready);
  c_ru_resume: cover property (rxs_q == PS_SUSPENDED ##1 rxs_q == PS_RUNNING);
endmodule

// [common/status_pkg.sv]
package status_pkg;
  localparam logic [7:0]  STATUS_OFFS    = 8'h00;
  localparam logic [7:0]  CONTROL_OFFS   = 8'h04;
  localparam int          OM_LSB         = 17;
  localparam int          DONE_BIT       = 16;
  localparam int          FLAGS_LSB      = 1;
  localparam int          CTL_IE_BIT     = 0;
  localparam int          CTL_OM_LSB     = 1;
  localparam logic [7:0]  RSVD_ONES      = 8'hff;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
  localparam logic [1:0]  OM_RESET       = 2'b00;
  localparam logic [1:0]  OM_NORMAL      = 2'b00;
  localparam logic [1:0]  OM_INT_LOOP    = 2'b01;
  localparam logic [1:0]  OM_EXT_LOOP    = 2'b10;
  localparam logic [1:0]  PS_STOPPED     = 2'b00;
  localparam logic [1:0]  PS_RUNNING     = 2'b01;
  localparam logic [1:0]  PS_SUSPENDED   = 2'b10;
  localparam int          START_PIN_CYC  = 6;

  typedef struct packed {
    logic boot_msg;
    logic tx_wdog;
    logic rx_wdog;
    logic bus_err;
    logic parity_err;
    logic rx_unavail;
    logic rx_frame_done;
    logic tx_list_end;
    logic tx_local_abort;
    logic tx_ic_done;
    logic rx_poll;
    logic tx_poll;
    logic rx_recognized;
    logic rx_start;
    logic tx_start;
    logic vacc_done;
    logic vacc_start;
  } events_s;

  typedef struct packed {
    logic rx_abort_mark;
    logic tx_wdog_mark;
    logic medium_off;
    logic loop_return;
  } actions_s;
endpackage

// [test/host_port_model.sv]
`timescale 1ns/10ps
// ----------------------------------------
// host driver model, axi4-lite master side
// ----------------------------------------
module host_port_model (
  input  wire logic        aclk,
  output logic [7:0]       s_awaddr,
  output logic             s_awvalid,
  input  wire logic        s_awready,
  output logic [31:0]      s_wdata,
  output logic [3:0]       s_wstrb,
  output logic             s_wvalid,
  input  wire logic        s_wready,
  input  wire logic [1:0]  s_bresp,
  input  wire logic        s_bvalid,
  output logic             s_bready,
  output logic [7:0]       s_araddr,
  output logic             s_arvalid,
  input  wire logic        s_arready,
  input  wire logic [31:0] s_rdata,
  input  wire logic [1:0]  s_rresp,
  input  wire logic        s_rvalid,
  output logic             s_rready
);
  initial begin
    {s_awaddr, s_awvalid, s_wdata, s_wstrb, s_wvalid, s_bready} = '0;
    {s_araddr, s_arvalid, s_rready} = '0;
  end
  // released payload is inverted so a stale value is never mistaken for a live one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_wstrb   <= 4'hf;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready) begin
        s_awvalid <= 1'b0;
        s_awaddr  <= ~s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        s_wvalid <= 1'b0;
        s_wdata  <= ~s_wdata;
      end
    end while (!s_bvalid);
    s_bready <= 1'b0;
    r = s_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arvalid && s_arready) begin
        s_arvalid <= 1'b0;
        s_araddr  <= ~s_araddr;
      end
    end while (!s_rvalid);
    s_rready <= 1'b0;
    d = s_rdata;
    r = s_rresp;
  endtask
endmodule

// [test/mac_status_flags_tb_top.sv]
`timescale 1ns/10ps
module mac_status_flags_tb_top
  import status_pkg::*;
;
  logic        aclk, aresetn, remote_start_pin, irq;
  logic [7:0]  s_awaddr, s_araddr;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [31:0] s_wdata, s_rdata, rdat;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, tx_state, rx_state, resp;
  events_s     ev;
  actions_s    act;
  int          errors, comparisons, cnt;
  localparam logic [31:0] BASE = 32'h0001_ff00;
  // event bit index, status low byte, {tx_state, rx_state} after the event
  int          ev_b[10] = '{16, 15, 14, 13, 12, 11, 10, 9, 8, 7};
  logic [7:0]  fl[10]   = '{8'h80, 8'h41, 8'h25, 8'h11, 8'h11, 8'h09, 8'h05, 8'h03, 8'h03, 8'h03};
  logic [3:0]  st[10]   = '{4'h5, 4'h1, 4'h5, 4'h0, 4'h0, 4'h6, 4'h5, 4'h9, 4'h9, 4'h5};

  mac_status_flags mac_status_flags_inst (.*);
  host_port_model host_port_model_inst (.*);

  // ----------------------------------------
  // clock, checks, helpers
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    host_port_model_inst.rd(a, rdat, resp);
    chk("rdata", rdat, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_port_model_inst.wr(a, d, resp);
  endtask
  // one-cycle event, then one edge for the flag to land
  task automatic pulse(input int b);
    ev <= events_s'(17'h0_0001 << b);
    @(posedge aclk);
    ev <= '0;
    @(posedge aclk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    report_and_stop();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    ev = '0;
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("irq", irq, 0);
    chk("state", {tx_state, rx_state}, 0);
    rdc(STATUS_OFFS, BASE);
    wr(STATUS_OFFS, 32'hffff_ffff);
    rdc(STATUS_OFFS, BASE);
    $display("reset values done");
    for (int i = 0; i < 10; i++) begin
      wr(CONTROL_OFFS, 32'h0000_0001);
      pulse(3);
      pulse(2);
      pulse(ev_b[i]);
      chk("irq", irq, fl[i][0]);
      chk("state", {tx_state, rx_state}, st[i]);
      rdc(STATUS_OFFS, {BASE[31:8], fl[i]});
      wr(STATUS_OFFS, 32'h0000_00fe);
      rdc(STATUS_OFFS, BASE);
      chk("irq", irq, 0);
    end
    wr(CONTROL_OFFS, 32'h0000_0000);
    pulse(10);
    chk("irq", irq, 0);
    wr(STATUS_OFFS, 32'h0000_0004);
    $display("event flags done");
    ev <= events_s'(17'h1_0000);
    cnt = 0;
    repeat (12) begin
      @(posedge aclk);
      ev <= '0;
      cnt += int'(remote_start_pin);
    end
    chk("pin", cnt, START_PIN_CYC);
    wr(STATUS_OFFS, 32'h0000_0080);
    // second unavailable descriptor while suspended must not re-flag
    pulse(3);
    pulse(11);
    wr(STATUS_OFFS, 32'h0000_0008);
    pulse(11);
    rdc(STATUS_OFFS, BASE);
    pulse(4);
    chk("rx", rx_state, PS_RUNNING);
    pulse(11);
    pulse(6);
    chk("rx", rx_state, PS_RUNNING);
    pulse(2);
    pulse(9);
    pulse(5);
    chk("tx", tx_state, PS_RUNNING);
    wr(STATUS_OFFS, 32'h0000_00fe);
    $display("process states done");
    for (int m = 0; m < 4; m++) begin
      wr(CONTROL_OFFS, 32'(m) << CTL_OM_LSB);
      rdc(STATUS_OFFS, BASE | (32'(m) << OM_LSB));
      chk("act", {act.medium_off, act.loop_return}, (m == 1) ? 3 : (m == 2) ? 1 : 0);
    end
    pulse(0);
    rdc(STATUS_OFFS, 32'h0006_ff00);
    pulse(1);
    rdc(STATUS_OFFS, 32'h0007_ff00);
    // done bit cleared again, then a mid-run reset must set it back
    pulse(0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(STATUS_OFFS, BASE);
    rdc(8'h08, 32'h0000_0000);
    chk("rresp", resp, RESP_SLVERR);
    wr(8'h08, 32'h0000_0001);
    chk("bresp", resp, RESP_SLVERR);
    $display("modes and access done");
    report_and_stop();
  end
endmodule
